// File: rtl/ifs_pkg.sv
package ifs_pkg;

   // Address and data widths of the program store.
   localparam int PC_W      = 12;
   localparam int WORD_W    = 16;
   localparam int ROM_DEPTH = 3072;

   // Phases per instruction cycle.
   localparam int PHASES = 4;

   // Start-up delay, in system clock periods.
   localparam int STARTUP_PERIODS = 1024;

   // Fixed program addresses.
   localparam logic [11:0] RESET_VECTOR = 12'h000;
   localparam logic [11:0] EXT_VECTOR   = 12'h004;
   localparam logic [11:0] TMR_VECTOR   = 12'h008;

   // Register offsets and reset values.
   localparam logic [7:0]  JTLB_OFFSET  = 8'h06;
   localparam logic [7:0]  JTLB_RESET   = 8'h00;

   // One-hot phase value after reset.
   localparam logic [3:0]  PHASE_RESET  = 4'h1;

   // Execute-stage control transfer request.
   typedef enum logic [2:0] {
      IFS_SEQ,
      IFS_SKIP,
      IFS_JUMP,
      IFS_CALL,
      IFS_RET
   } ifs_ctl_t;

   // Control request from the decoder, valid on the last phase.
   typedef struct packed {
      ifs_ctl_t    ctl;
      logic [11:0] target;
   } ifs_req_t;

endpackage

// File: rtl/ifs_sequencer.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
module ifs_sequencer #(
   parameter int STARTUP_PERIODS = ifs_pkg::STARTUP_PERIODS,
   parameter int ROM_DEPTH       = ifs_pkg::ROM_DEPTH
) (
   // Clock and reset.
   input  wire logic                clk_sys,
   input  wire logic                srst,
   // Wake-up from the halted state.
   input  wire logic                wake,
   // Program store port.
   output logic [11:0]              rom_addr,
   output logic                     rom_rd,
   input  wire logic [15:0]         rom_data,
   // Table read request.
   input  wire logic                tbl_rd,
   input  wire logic [11:0]         tbl_addr,
   // Decoded instruction to the execute stage.
   output logic [15:0]              instr,
   output logic                     instr_valid,
   output logic [3:0]               phase,
   output logic                     cycle_end,
   // Control request from the execute stage.
   input  wire ifs_pkg::ifs_req_t   req,
   input  wire logic                skip_true,
   // Interrupt requests.
   input  wire logic                ext_int,
   input  wire logic                tmr_int,
   input  wire logic                int_en,
   input  wire logic                stack_full,
   output logic                     int_ack,
   // Return stack port.
   output logic                     push,
   output logic [11:0]              push_addr,
   output logic                     pop,
   input  wire logic [11:0]         pop_addr,
   // Register port.
   input  wire logic [7:0]          reg_addr,
   input  wire logic [7:0]          reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic [7:0]               reg_rdata,
   output logic                     running
);

   initial
   begin
      // The pointer is twelve bits wide and the start-up counter eleven.
      if (ROM_DEPTH > 4096 || ROM_DEPTH < 1)
         $error("ifs_sequencer: unsupported store depth");
      if (STARTUP_PERIODS < 1 || STARTUP_PERIODS > 2047)
         $error("ifs_sequencer: unsupported start-up delay");
   end

   logic [11:0] ip;
   logic [10:0] st_cnt;
   logic        dummy;
   // Three-stage synchroniser on the wake pin, then a filtered level.
   logic        wake_s1;
   logic        wake_s2;
   logic        wake_s3;
   logic        wake_lvl;
   logic        wake_rise;
   logic        restart;
   logic [11:0] next_ip;
   logic        last_ph;
   logic        jtlb_wr;
   logic        jtlb_rd;
   logic        take_ext;
   logic        take_tmr;
   logic        xfer;
   logic        exec_end;
   logic        is_jump;
   logic        is_call;
   logic        is_ret;
   logic        skip_hit;

   // Next sequential address; the twelve-bit sum wraps at the top.
   function automatic logic [11:0] inc_ip(input logic [11:0] cur);
      return cur + 12'h001;
   endfunction

   // Register decode.
   assign jtlb_wr = reg_wr && reg_addr == ifs_pkg::JTLB_OFFSET;
   assign jtlb_rd = reg_rd && reg_addr == ifs_pkg::JTLB_OFFSET;

   assign last_ph   = phase[3];
   assign cycle_end = last_ph && running;

   // A low byte write in the last phase wins over the executing word, so an
   // interrupt, a push or a pop would be lost; push and pop are dropped, and an interrupt waits past the dummy slot.
   assign exec_end = cycle_end && !jtlb_wr;

   // Decoded request of the executing word; a dummy slot never executes.
   assign is_jump  = instr_valid && req.ctl == ifs_pkg::IFS_JUMP;
   assign is_call  = instr_valid && req.ctl == ifs_pkg::IFS_CALL;
   assign is_ret   = instr_valid && req.ctl == ifs_pkg::IFS_RET;
   assign skip_hit = instr_valid && req.ctl == ifs_pkg::IFS_SKIP && skip_true;

   assign take_ext = ext_int && int_en && !stack_full && !dummy;
   assign take_tmr = tmr_int && int_en && !stack_full && !dummy && !take_ext;
   assign int_ack  = exec_end && (take_ext || take_tmr);

   // Any transfer that makes the prefetched word a dummy.
   assign xfer = int_ack || jtlb_wr || is_jump || is_call || is_ret || skip_hit;

   always_comb
   begin
      next_ip = inc_ip(ip);
      if (int_ack)
         next_ip = take_ext ? ifs_pkg::EXT_VECTOR : ifs_pkg::TMR_VECTOR;
      else if (instr_valid)
      begin
         unique case (req.ctl)
            ifs_pkg::IFS_JUMP, ifs_pkg::IFS_CALL: next_ip = req.target;
            ifs_pkg::IFS_RET:  next_ip = pop_addr;
            ifs_pkg::IFS_SKIP: next_ip = inc_ip(ip);
            ifs_pkg::IFS_SEQ:  next_ip = inc_ip(ip);
            // Codes outside the enumeration fall through to the next word.
            default:           next_ip = inc_ip(ip);
         endcase
      end
   end

   assign push      = exec_end && (int_ack || is_call);
   assign push_addr = ip;
   assign pop       = exec_end && is_ret;

   assign rom_addr = tbl_rd ? tbl_addr : ip;
   assign rom_rd   = running && (phase[0] || tbl_rd);

   always_ff @(posedge clk_sys)
   begin
      if (srst || !running)
         phase <= ifs_pkg::PHASE_RESET;
      else
         phase <= {phase[2:0], phase[3]};
   end

   // Wake pin synchroniser; the first stage feeds only the second.
   always_ff @(posedge clk_sys)
   begin
      wake_s1 <= wake;
      wake_s2 <= wake_s1;
      wake_s3 <= wake_s2;
   end

   // Filtered wake level, which follows once stages two and three agree.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         wake_lvl <= 1'b0;
      else if (wake_s2 == wake_s3)
         wake_lvl <= wake_s3;
   end

   // A settled rising wake restarts the start-up delay, as reset does.
   assign wake_rise = wake_s2 && wake_s3 && !wake_lvl;
   assign restart   = srst || wake_rise;

   always_ff @(posedge clk_sys)
   begin
      if (restart)
      begin
         st_cnt  <= '0;
         running <= 1'b0;
      end
      else if (!running)
      begin
         st_cnt  <= st_cnt + 11'h001;
         running <= 32'(st_cnt) + 1 >= STARTUP_PERIODS;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst || !running)
      begin
         instr       <= '0;
         instr_valid <= 1'b0;
         dummy       <= 1'b0;
      end
      else if (cycle_end)
      begin
         instr       <= rom_data;
         instr_valid <= !xfer;
         dummy       <= xfer;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
         ip <= ifs_pkg::RESET_VECTOR;
      else if (running && jtlb_wr)
         ip <= {ip[11:8], reg_wdata};
      else if (cycle_end)
         ip <= next_ip;
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
         reg_rdata <= ifs_pkg::JTLB_RESET;
      else
         reg_rdata <= jtlb_rd ? ip[7:0] : 8'h00;
   end

endmodule

// File: testbench/ifs_properties.sv
`timescale 1ns/100ps
module ifs_properties #(parameter int STARTUP_PERIODS = 8) (
   // Clock, reset and status.
   input wire logic clk_sys, srst, running, cycle_end, instr_valid,
   // Control, interrupts, table and register port.
   input wire logic int_ack, push, ext_int, int_en, stack_full, tbl_rd, rom_rd, skip_true,
   input wire logic reg_wr, reg_rd,
   input wire logic [11:0] rom_addr, tbl_addr,
   input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
   input wire ifs_pkg::ifs_req_t req
);
   localparam int LO = STARTUP_PERIODS - 2;
   localparam int HI = STARTUP_PERIODS + 1;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   // Executed, non-interrupted request and the upper pointer bits.
   wire logic       go = cycle_end && instr_valid && !int_ack &&
                         !(reg_wr && reg_addr == ifs_pkg::JTLB_OFFSET);
   wire logic [3:0] hi = rom_addr[11:8];
   cycle_space_a: assert property (cycle_end |=> !cycle_end [*3] ##1 (cycle_end || !running))
      else $error("cycle spacing");
   table_addr_a: assert property (tbl_rd |-> rom_rd && rom_addr == tbl_addr)
      else $error("table address");
   seq_step_a: assert property (go && !tbl_rd && req.ctl == ifs_pkg::IFS_SEQ ##1 !tbl_rd |-> rom_addr == $past(rom_addr) + 12'h001)
      else $error("no increment");
   jump_load_a: assert property (go && !tbl_rd && req.ctl == ifs_pkg::IFS_JUMP ##1 !tbl_rd |-> rom_addr == $past(req.target) && !instr_valid)
      else $error("jump load");
   skip_drop_a: assert property (go && req.ctl == ifs_pkg::IFS_SKIP && skip_true |=> !instr_valid)
      else $error("skip kept word");
   int_vector_a: assert property (int_ack && !tbl_rd ##1 !tbl_rd |-> rom_addr == ($past(ext_int) ? ifs_pkg::EXT_VECTOR : ifs_pkg::TMR_VECTOR))
      else $error("vector");
   int_gate_a: assert property (int_ack |-> cycle_end && int_en && !stack_full && push)
      else $error("interrupt gate");
   low_write_a: assert property (reg_wr && reg_addr == ifs_pkg::JTLB_OFFSET && running && !cycle_end && !tbl_rd ##1 !tbl_rd |-> hi == $past(hi) && rom_addr[7:0] == $past(reg_wdata))
      else $error("low byte write");
   read_idle_a: assert property (reg_rd && reg_addr != ifs_pkg::JTLB_OFFSET |=> reg_rdata == 8'h00)
      else $error("unmapped read");
   start_wait_a: assert property ($fell(srst) |-> !running ##[LO:HI] running)
      else $error("start delay");
   reset_clear_a: assert property (disable iff (1'b0) srst |=> rom_addr == ifs_pkg::RESET_VECTOR && !running)
      else $error("reset pointer");
   cover property (int_ack);
   cover property (go && req.ctl == ifs_pkg::IFS_RET);
   cover property (reg_wr && running);
endmodule
bind ifs_sequencer ifs_properties #(.STARTUP_PERIODS(STARTUP_PERIODS)) u_props (.*);

// File: testbench/ifs_rom_model.sv
`timescale 1ns/100ps
module ifs_rom_model (
   // Fetch address in, word out.
   input wire logic [11:0] rom_addr,
   output logic     [15:0] rom_data
);
   // word per address
   // Past the store the cells read as all ones, like unprogrammed ones.
   assign rom_data = (rom_addr < ifs_pkg::ROM_DEPTH) ? {~rom_addr[3:0], rom_addr} : 16'hffff;
endmodule

// File: testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
   logic clk_sys = 0, srst = 1, wake = 0, tbl_rd = 0, skip_true = 0, ext_int = 0, tmr_int = 0;
   logic int_en = 0, stack_full = 0, reg_wr = 0, reg_rd = 0, rom_rd, instr_valid, cycle_end;
   logic int_ack, push, pop, running, ev, v;
   logic [3:0]  phase;
   logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata;
   logic [11:0] tbl_addr = 0, pop_addr = 0, rom_addr, push_addr, pc, nx;
   logic [15:0] rom_data, instr, w;
   ifs_pkg::ifs_req_t req = '0;
   int err_total = 0, num_checks = 0, n = 0;
   ifs_sequencer #(.STARTUP_PERIODS(8)) dut (.*);
   ifs_rom_model rom (.rom_addr(rom_addr), .rom_data(rom_data));
   initial forever #5 clk_sys = ~clk_sys;
   // Compares one result and counts it.
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("mismatches %0d checks %0d", err_total, num_checks);
      if (err_total == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // One register cycle; a read is compared in the cycle after its strobe.
   task automatic reg_op(input logic wr, input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      {reg_wr, reg_rd, reg_addr, reg_wdata} <= {wr, !wr, a, exp};
      @(posedge clk_sys);
      {reg_wr, reg_rd} <= 2'b00;
      @(negedge clk_sys);
      if (!wr) check(reg_rdata, exp);
   endtask
   initial
   begin
      #40000 err_total++;
      end_sim;
   end
   initial
   begin
      void'($urandom(75411));
      repeat (3) @(posedge clk_sys);
      srst <= 0;
      reg_op(1, 8'h06, 8'h5a);
      reg_op(0, 8'h06, 8'h00);
      for (int i = 0; i < 20 && running !== 1'b1; i++) @(negedge clk_sys);
      check(rom_addr, 12'h000);
      pc = 12'h000;
      while (n < 150)
      begin
         @(posedge clk_sys);
         req <= '{ifs_pkg::ifs_ctl_t'($urandom_range(4)), 12'($urandom)};
         {skip_true, ext_int, tmr_int, stack_full, pop_addr} <= 16'($urandom);
         int_en <= $urandom_range(3) == 0;
         @(negedge clk_sys);
         if (cycle_end === 1'b1)
         begin
            ev = (instr_valid || n == 0) && int_en && !stack_full && (ext_int || tmr_int);
            w = (pc < ifs_pkg::ROM_DEPTH) ? {~pc[3:0], pc} : 16'hffff;
            nx = pc + 12'h001;
            v = !instr_valid || req.ctl == ifs_pkg::IFS_SEQ;
            v = v || (req.ctl == ifs_pkg::IFS_SKIP && !skip_true);
            if (ev) nx = ext_int ? ifs_pkg::EXT_VECTOR : ifs_pkg::TMR_VECTOR;
            else if (!v && req.ctl == ifs_pkg::IFS_RET) nx = pop_addr;
            else if (!v && req.ctl != ifs_pkg::IFS_SKIP) nx = req.target;
            v = v && !ev;
            check(int_ack, ev);
            @(negedge clk_sys);
            check(rom_addr, nx);
            check(instr_valid, v);
            check(instr, w);
            pc = nx;
            n++;
         end
      end
      @(posedge clk_sys);
      req <= '0;
      {skip_true, ext_int, tmr_int, stack_full, int_en} <= 5'h00;
      // Write in the first phase, so no cycle end falls before the read-back.
      do @(negedge clk_sys); while (cycle_end !== 1'b1);
      reg_op(1, 8'h06, 8'hc3);
      reg_op(0, 8'h06, 8'hc3);
      reg_op(0, 8'h07, 8'h00);
      @(posedge clk_sys);
      tbl_rd <= 1;
      tbl_addr <= 12'h9e1;
      @(negedge clk_sys);
      check(rom_addr, 12'h9e1);
      check(rom_data, {4'he, 12'h9e1});
      check(running, 1'b1);
      @(posedge clk_sys);
      {tbl_rd, wake} <= 2'b01;
      // The wake pin is filtered, so it stands for three clocks.
      repeat (3) @(posedge clk_sys);
      wake <= 0;
      repeat (2) @(negedge clk_sys);
      check(running, 1'b0);
      repeat (10) @(negedge clk_sys);
      check(running, 1'b1);
      end_sim;
   end
endmodule
